// *** shared/dprc_map.vh ***
`ifndef DPRC_MAP_VH
`define DPRC_MAP_VH
// ----------------------------------------
// register offsets, lower 16 address bits
// ----------------------------------------
`define DPRC_OFS_CTRL 16'hffac
`define DPRC_OFS_TCSR 16'hffad
`define DPRC_OFS_CNT 16'hffae
`define DPRC_OFS_COR 16'hffaf
`define DPRC_OFS_MEMCFG 16'hffb0
// ----------------------------------------
// reset values
// ----------------------------------------
`define DPRC_RST_CTRL 8'h02
`define DPRC_RST_TCSR 8'h07
`define DPRC_RST_CNT 8'h00
`define DPRC_RST_COR 8'hff
`define DPRC_RST_WAIT 2'h0
// ----------------------------------------
// control register fields
// ----------------------------------------
`define DPRC_B_SELF 7
`define DPRC_B_PSR 6
`define DPRC_B_DRAM 5
`define DPRC_B_STRB 4
`define DPRC_B_COLW 3
`define DPRC_B_RPIN 2
`define DPRC_B_RSV 1
`define DPRC_B_RCYC 0
`define DPRC_MASK_LOCK 8'h1d
// ----------------------------------------
// timer status fields
// ----------------------------------------
`define DPRC_B_MF 7
`define DPRC_B_MIE 6
`define DPRC_CKS_HI 5
`define DPRC_CKS_LO 3
`define DPRC_TCSR_ONES 3'h7
// ----------------------------------------
// prescaler and memory limits
// ----------------------------------------
`define DPRC_PRE_W 12
`define DPRC_LIM_1M 22'h020000
`define DPRC_LIM_16M 22'h200000
`define DPRC_CYC_LEN 2'h2
`endif

// *** rtl/dprc_strobe_mux.v ***
`timescale 1ns/10ps
`default_nettype none
module dprc_strobe_mux
(
   input wire dyn_mode,
   input wire dual_column_strobe_mode,
   input wire col9,
   input wire [20:0] addr,
   input wire phase_col,
   input wire rd_n,
   input wire hw_n,
   input wire lw_n,
   input wire cs3_n,
   input wire refresh_n,
   output reg upper_write_or_column_strobe,
   output reg lower_write_or_column_strobe,
   output reg rd_pin,
   output reg area3_select_pin,
   output reg [9:0] mux_addr
);
   always @*
   begin
      mux_addr = phase_col ? (col9 ? {1'b0, addr[9:1]} : {2'b00, addr[8:1]})
         : (col9 ? addr[19:10] : addr[18:9]);
      upper_write_or_column_strobe = hw_n;
      lower_write_or_column_strobe = lw_n;
      rd_pin = rd_n;
      area3_select_pin = cs3_n;
      if (dyn_mode)
      begin
         area3_select_pin = cs3_n;
         if (dual_column_strobe_mode)
         begin
            upper_write_or_column_strobe = hw_n & refresh_n;
            lower_write_or_column_strobe = lw_n & refresh_n;
            rd_pin = rd_n;
         end
         else
         begin
            rd_pin = rd_n & refresh_n;
         end
      end
   end
endmodule // dprc_strobe_mux
`default_nettype wire

// *** rtl/dprc_top.v ***
`timescale 1ns/10ps
`default_nettype none
`include "dprc_map.vh"
// Operation
// - dynamic or pseudo-static memory attaches only in external area 3
// - one-megabyte modes limit attached memory to 128 kbytes
// - sixteen-megabyte modes limit attached memory to 2 Mbytes
// - one function at a time: dynamic, pseudo-static, or timer
// - without refresh the block works as an 8-bit interval timer
// - a halt request stops the block to save power
// - supports 16-bit dynamic memory without glue logic
// - column multiplexing uses 8 or 9 bits, chosen by software
// - wait states may be added to area-3 memory accesses
// - counter counts up on one of seven prescaled clocks
// - counter equal to constant raises an interrupt in timer use
// - refresh pin goes low during each refresh cycle
// - upper strobe is upper write or upper column strobe by mode
// - lower strobe is lower write or lower column strobe by mode
// - control register bits select self-refresh, memories, strobes, width, pins
// - control register resets to 0x02, bit 1 always reads one
// - timer control and status register resets to 0x07
// - time constant register resets to 0xff
// - pseudo-static mode with self-refresh set enters self-refresh in standby
// - dynamic mode with self-refresh set enters self-refresh in standby
// - leaving standby returns memory to normal access
// - registers decode on lower 16 address bits only
// - enable bits: none timer, one memory type, both illegal
// - with both enables clear no refresh cycles are inserted
// - with a memory enabled area-3 and refresh cycles take three states
// - with a memory enabled lock bits 0,2,3,4 and timers, except flag clear
module dprc_top
(
   input wire hclk,
   input wire hresetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg [31:0] hrdata,
   output reg hreadyout,
   output reg hresp,
   input wire halt_req,
   input wire hw_standby,
   input wire sw_standby,
   input wire wide_space_mode,
   input wire area3_access,
   input wire [20:0] area3_addr,
   input wire rd_n,
   input wire hw_n,
   input wire lw_n,
   input wire cs3_n,
   input wire bus_grant,
   output reg refresh_request,
   output reg area3_three_state,
   output reg [1:0] area3_wait_states,
   output reg area3_addr_ok,
   output reg timer_irq,
   output reg refresh_strobe_out,
   output reg refresh_pin_oe,
   output reg upper_write_strobe_pin,
   output reg lower_write_strobe_pin,
   output reg read_strobe_pin,
   output reg area3_select_pin,
   output reg [9:0] dram_addr,
   output reg self_refresh_active
);
   // ----------------------------------------
   // registers
   // ----------------------------------------
   reg [7:0] refresh_control;
   reg [7:0] refresh_timer_control_status;
   reg [7:0] refresh_timer_count;
   reg [7:0] refresh_time_constant;
   reg [1:0] wait_cfg;
   reg [`DPRC_PRE_W-1:0] prescale;
   reg [`DPRC_PRE_W-1:0] prescale_d;
   reg [1:0] ref_state;
   reg [1:0] ref_cnt;
   reg ref_pending;
   reg sb_meta;
   reg sb_sync;
   reg halt_meta;
   reg halt_sync;
   reg hws_meta;
   reg hws_sync;
   reg flag_seen;
   reg dph_wr;
   reg [15:0] dph_addr;
   localparam ST_IDLE = 2'b00;
   localparam ST_CAS = 2'b01;
   localparam ST_RAS = 2'b10;
   localparam ST_SELF = 2'b11;
   wire psr_en = refresh_control[`DPRC_B_PSR];
   wire dyn_en = refresh_control[`DPRC_B_DRAM];
   wire mem_en = psr_en | dyn_en;
   wire dyn_mode = dyn_en & ~psr_en;
   wire psr_mode = psr_en & ~dyn_en;
   wire legal_mem = dyn_mode | psr_mode;
   wire [2:0] cks = refresh_timer_control_status[`DPRC_CKS_HI:`DPRC_CKS_LO];
   // ----------------------------------------
   // clock source select
   // ----------------------------------------
   function tick_sel;
      input [2:0] sel;
      input [`DPRC_PRE_W-1:0] now;
      input [`DPRC_PRE_W-1:0] old;
      reg [`DPRC_PRE_W-1:0] fall;
      begin
         fall = old & ~now;
         case (sel)
            3'h1: tick_sel = fall[0];
            3'h2: tick_sel = fall[2];
            3'h3: tick_sel = fall[4];
            3'h4: tick_sel = fall[6];
            3'h5: tick_sel = fall[8];
            3'h6: tick_sel = fall[10];
            3'h7: tick_sel = fall[11];
            default: tick_sel = 1'b0;
         endcase
      end
   endfunction
   wire tick = ~halt_sync & tick_sel(cks, prescale, prescale_d);
   wire match = tick & (refresh_timer_count == refresh_time_constant);
   wire take = hsel & hready & htrans[1];
   wire do_wr = dph_wr;
   wire wr_ctrl = do_wr & (dph_addr == `DPRC_OFS_CTRL);
   wire wr_tcsr = do_wr & (dph_addr == `DPRC_OFS_TCSR);
   wire wr_cnt = do_wr & (dph_addr == `DPRC_OFS_CNT) & ~mem_en;
   wire wr_cor = do_wr & (dph_addr == `DPRC_OFS_COR) & ~mem_en;
   wire [7:0] wb = hwdata[7:0];
   wire [7:0] ctrl_keep = mem_en ? `DPRC_MASK_LOCK : 8'h00;
   wire clr_flag = wr_tcsr & ~wb[`DPRC_B_MF] & flag_seen;
   wire [21:0] mem_limit = wide_space_mode ? `DPRC_LIM_16M : `DPRC_LIM_1M;
   // ----------------------------------------
   // ahb slave and register file
   // ----------------------------------------
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         dph_wr <= 1'b0;
         dph_addr <= 16'h0000;
         hrdata <= 32'h00000000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         flag_seen <= 1'b0;
      end
      else
      begin
         dph_wr <= take & hwrite;
         dph_addr <= haddr[17:2];
         if (take & ~hwrite)
         begin
            if (haddr[17:2] == `DPRC_OFS_CTRL)
               hrdata <= {24'h000000, refresh_control};
            else if (haddr[17:2] == `DPRC_OFS_TCSR)
               hrdata <= {24'h000000, refresh_timer_control_status};
            else if (haddr[17:2] == `DPRC_OFS_CNT)
               hrdata <= {24'h000000, refresh_timer_count};
            else if (haddr[17:2] == `DPRC_OFS_COR)
               hrdata <= {24'h000000, refresh_time_constant};
            else if (haddr[17:2] == `DPRC_OFS_MEMCFG)
               hrdata <= {30'h00000000, wait_cfg};
            else
               hrdata <= 32'h00000000;
            if (haddr[17:2] == `DPRC_OFS_TCSR)
               flag_seen <= refresh_timer_control_status[`DPRC_B_MF];
         end
         else if (clr_flag)
            flag_seen <= 1'b0;
      end
   end
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         refresh_control <= `DPRC_RST_CTRL;
         refresh_timer_control_status <= `DPRC_RST_TCSR;
         refresh_timer_count <= `DPRC_RST_CNT;
         refresh_time_constant <= `DPRC_RST_COR;
         wait_cfg <= `DPRC_RST_WAIT;
      end
      else if (hws_sync)
      begin
         refresh_control <= `DPRC_RST_CTRL;
         refresh_timer_control_status <= `DPRC_RST_TCSR;
         refresh_timer_count <= `DPRC_RST_CNT;
         refresh_time_constant <= `DPRC_RST_COR;
      end
      else
      begin
         if (wr_ctrl)
            refresh_control <= ((wb & ~ctrl_keep) | (refresh_control & ctrl_keep))
               | (8'h01 << `DPRC_B_RSV);
         if (do_wr & (dph_addr == `DPRC_OFS_MEMCFG))
            wait_cfg <= hwdata[1:0];
         if (match)
            refresh_timer_control_status[`DPRC_B_MF] <= 1'b1;
         else if (clr_flag)
            refresh_timer_control_status[`DPRC_B_MF] <= 1'b0;
         if (mem_en)
            refresh_timer_control_status[`DPRC_B_MIE] <= 1'b0;
         else if (wr_tcsr)
            refresh_timer_control_status[`DPRC_B_MIE] <= wb[`DPRC_B_MIE];
         if (wr_tcsr & ~mem_en)
            refresh_timer_control_status[`DPRC_CKS_HI:`DPRC_CKS_LO] <=
               wb[`DPRC_CKS_HI:`DPRC_CKS_LO];
         refresh_timer_control_status[2:0] <= `DPRC_TCSR_ONES;
         if (sb_sync)
            refresh_timer_control_status[`DPRC_B_MIE] <= 1'b0;
         if (wr_cnt)
            refresh_timer_count <= wb;
         else if (match)
            refresh_timer_count <= `DPRC_RST_CNT;
         else if (tick)
            refresh_timer_count <= refresh_timer_count + 8'h01;
         if (wr_cor)
            refresh_time_constant <= wb;
      end
   end
   // ----------------------------------------
   // prescaler and pin synchronisers
   // ----------------------------------------
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         prescale <= {`DPRC_PRE_W{1'b0}};
         prescale_d <= {`DPRC_PRE_W{1'b0}};
         sb_meta <= 1'b0;
         sb_sync <= 1'b0;
         halt_meta <= 1'b0;
         halt_sync <= 1'b0;
         hws_meta <= 1'b0;
         hws_sync <= 1'b0;
      end
      else
      begin
         prescale <= halt_sync ? prescale : prescale + 1'b1;
         prescale_d <= prescale;
         sb_meta <= sw_standby;
         sb_sync <= sb_meta;
         halt_meta <= halt_req;
         halt_sync <= halt_meta;
         hws_meta <= hw_standby;
         hws_sync <= hws_meta;
      end
   end
   // ----------------------------------------
   // refresh sequencer
   // ----------------------------------------
   wire self_ok = refresh_control[`DPRC_B_SELF] & legal_mem & sb_sync;
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ref_state <= ST_IDLE;
         ref_cnt <= 2'h0;
         ref_pending <= 1'b0;
      end
      else
      begin
         if (match & legal_mem & refresh_control[`DPRC_B_RCYC])
            ref_pending <= 1'b1;
         else if ((ref_state == ST_CAS) | ~legal_mem)
            ref_pending <= 1'b0;
         case (ref_state)
            ST_IDLE:
            begin
               ref_cnt <= 2'h0;
               if (self_ok)
                  ref_state <= ST_SELF;
               else if (ref_pending & bus_grant & ~halt_sync)
                  ref_state <= ST_CAS;
            end
            ST_CAS:
            begin
               ref_cnt <= ref_cnt + 2'h1;
               ref_state <= ST_RAS;
            end
            ST_RAS:
            begin
               ref_cnt <= ref_cnt + 2'h1;
               if (ref_cnt == `DPRC_CYC_LEN)
                  ref_state <= ST_IDLE;
            end
            ST_SELF:
            begin
               if (~sb_sync | ~legal_mem)
                  ref_state <= ST_IDLE;
            end
            default:
               ref_state <= ST_IDLE;
         endcase
      end
   end
   wire in_ref = (ref_state != ST_IDLE);
   wire [3:0] mux_strobes;
   wire [9:0] mux_addr;
   dprc_strobe_mux u_mux
   (
      .dyn_mode(dyn_mode),
      .dual_column_strobe_mode(refresh_control[`DPRC_B_STRB]),
      .col9(refresh_control[`DPRC_B_COLW]),
      .addr(area3_addr),
      .phase_col(rd_n & hw_n & lw_n ? 1'b0 : 1'b1),
      .rd_n(rd_n),
      .hw_n(hw_n),
      .lw_n(lw_n),
      .cs3_n(cs3_n & ~(dyn_mode & (ref_state == ST_RAS | ref_state == ST_SELF))),
      .refresh_n(~in_ref),
      .upper_write_or_column_strobe(mux_strobes[3]),
      .lower_write_or_column_strobe(mux_strobes[2]),
      .rd_pin(mux_strobes[1]),
      .area3_select_pin(mux_strobes[0]),
      .mux_addr(mux_addr)
   );
   // ----------------------------------------
   // registered outputs
   // ----------------------------------------
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         refresh_request <= 1'b0;
         area3_three_state <= 1'b0;
         area3_wait_states <= 2'h0;
         area3_addr_ok <= 1'b0;
         timer_irq <= 1'b0;
         refresh_strobe_out <= 1'b1;
         refresh_pin_oe <= 1'b0;
         upper_write_strobe_pin <= 1'b1;
         lower_write_strobe_pin <= 1'b1;
         read_strobe_pin <= 1'b1;
         area3_select_pin <= 1'b1;
         dram_addr <= 10'h000;
         self_refresh_active <= 1'b0;
      end
      else
      begin
         refresh_request <= ref_pending & legal_mem & (ref_state == ST_IDLE);
         area3_three_state <= mem_en | in_ref;
         area3_wait_states <= mem_en ? wait_cfg : 2'h0;
         area3_addr_ok <= area3_access & legal_mem
            & ({1'b0, area3_addr} < mem_limit);
         timer_irq <= refresh_timer_control_status[`DPRC_B_MF]
            & refresh_timer_control_status[`DPRC_B_MIE] & ~mem_en;
         refresh_strobe_out <= ~in_ref;
         refresh_pin_oe <= refresh_control[`DPRC_B_RPIN];
         upper_write_strobe_pin <= mux_strobes[3];
         lower_write_strobe_pin <= mux_strobes[2];
         read_strobe_pin <= mux_strobes[1];
         area3_select_pin <= mux_strobes[0];
         dram_addr <= mux_addr;
         self_refresh_active <= (ref_state == ST_SELF);
      end
   end
endmodule // dprc_top
`default_nettype wire

// *** bench/dprc_top_assertions.sv ***
`timescale 1ns/10ps
`default_nettype none
module dprc_top_assertions
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [31:0] hrdata,
   input wire logic sw_standby,
   input wire logic hw_standby,
   input wire logic bus_grant,
   input wire logic refresh_request,
   input wire logic area3_three_state,
   input wire logic timer_irq,
   input wire logic refresh_strobe_out,
   input wire logic self_refresh_active
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ----------------------------------------
   // refresh steps
   // ----------------------------------------
   sequence s_grant;
      refresh_request && bus_grant;
   endsequence
   sequence s_low3;
      (!refresh_strobe_out)[*3];
   endsequence
   AST_GRANT_STROBE: assert property (s_grant |-> ##[1:4] !refresh_strobe_out)
      else $error("refresh strobe did not follow grant");
   AST_CYCLE_LEN: assert property ($fell(refresh_strobe_out) |-> s_low3)
      else $error("refresh strobe low too short");
   AST_REQ_MEM: assert property (refresh_request |-> area3_three_state)
      else $error("refresh request in timer use");
   AST_STROBE_MEM: assert property (!refresh_strobe_out |-> area3_three_state)
      else $error("refresh strobe low without memory");
   AST_IRQ_TIMER: assert property (timer_irq |-> !area3_three_state)
      else $error("timer interrupt in memory use");
   AST_SELF_LOW: assert property (self_refresh_active |-> area3_three_state)
      else $error("self refresh without memory");
   AST_SELF_ENTRY: assert property ($rose(self_refresh_active) |-> sw_standby)
      else $error("self refresh without standby");
   AST_SELF_EXIT: assert property ($fell(sw_standby) |-> ##[1:6] !self_refresh_active)
      else $error("self refresh kept after standby");
   AST_HW_STBY: assert property (hw_standby[*5] |-> !area3_three_state && !timer_irq)
      else $error("hardware standby left control set");
   AST_RDATA: assert property (hrdata[31:8] == 24'h000000)
      else $error("read data upper bits set");
endmodule // dprc_top_assertions
bind dprc_top dprc_top_assertions i_dprc_top_assertions
(
   .hclk(hclk),
   .hresetn(hresetn),
   .hrdata(hrdata),
   .sw_standby(sw_standby),
   .hw_standby(hw_standby),
   .bus_grant(bus_grant),
   .refresh_request(refresh_request),
   .area3_three_state(area3_three_state),
   .timer_irq(timer_irq),
   .refresh_strobe_out(refresh_strobe_out),
   .self_refresh_active(self_refresh_active)
);
`default_nettype wire

// *** bench/dprc_mem_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module dprc_mem_model
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic slow,
   input wire logic refresh_request,
   input wire logic read_strobe_pin,
   input wire logic area3_select_pin,
   output logic bus_grant,
   output int cbr_count
);
   logic [2:0] wait_cnt;
   logic row_prev;
   // grant promptly or after three cycles, dropped with the request
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         bus_grant <= 1'b0;
         wait_cnt <= 3'h0;
      end
      else if (!refresh_request)
      begin
         bus_grant <= 1'b0;
         wait_cnt <= 3'h0;
      end
      else if (wait_cnt >= (slow ? 3'h3 : 3'h0))
         bus_grant <= 1'b1;
      else
         wait_cnt <= wait_cnt + 3'h1;
   end
   // memory refreshes when column strobe is low as row strobe falls
   always @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         row_prev <= 1'b1;
         cbr_count <= 0;
      end
      else
      begin
         row_prev <= area3_select_pin;
         if (row_prev && !area3_select_pin && !read_strobe_pin)
            cbr_count <= cbr_count + 1;
      end
   end
endmodule // dprc_mem_model
`default_nettype wire

// *** bench/tb_dprc_top.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "dprc_map.vh"
module tb_dprc_top;
   typedef struct {logic w; logic [31:0] a; logic [7:0] d; logic [7:0] e;} dprc_row_t;
   logic hclk, hresetn, hsel, hwrite, halt_req, hw_standby, sw_standby, slow;
   logic wide_space_mode, area3_access;
   logic [31:0] haddr, hwdata, rd, v1;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [20:0] area3_addr;
   wire [31:0] hrdata;
   wire [9:0] dram_addr;
   wire [1:0] area3_wait_states;
   wire hreadyout, hresp, bus_grant, refresh_request, area3_three_state, area3_addr_ok;
   wire timer_irq, refresh_strobe_out, self_refresh_active, read_strobe_pin, area3_select_pin;
   wire refresh_pin_oe;
   int cbr_count;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   dprc_row_t rows [11] = '{
      '{0, {16'h0, `DPRC_OFS_CTRL}, 8'h00, 8'h02}, '{0, {16'h0, `DPRC_OFS_TCSR}, 8'h00, 8'h07},
      '{0, {16'h0, `DPRC_OFS_CNT}, 8'h00, 8'h00}, '{0, {16'h0, `DPRC_OFS_COR}, 8'h00, 8'hff},
      '{0, 32'h0000ffb4, 8'h00, 8'h00}, '{1, {16'h0, `DPRC_OFS_CTRL}, 8'h00, 8'h00},
      '{0, {16'h0, `DPRC_OFS_CTRL}, 8'h00, 8'h02}, '{1, {16'h5a5a, `DPRC_OFS_COR}, 8'h40, 8'h00},
      '{0, {16'h0, `DPRC_OFS_COR}, 8'h00, 8'h40}, '{1, {16'h0, `DPRC_OFS_CNT}, 8'h03, 8'h00},
      '{0, {16'hc3c3, `DPRC_OFS_CNT}, 8'h00, 8'h03}};
   dprc_top i_dprc_top
   (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .halt_req(halt_req), .hw_standby(hw_standby),
      .sw_standby(sw_standby), .wide_space_mode(wide_space_mode), .area3_access(area3_access),
      .area3_addr(area3_addr), .rd_n(1'b1), .hw_n(1'b1), .lw_n(1'b1), .cs3_n(1'b1),
      .bus_grant(bus_grant), .refresh_request(refresh_request),
      .area3_three_state(area3_three_state), .area3_wait_states(area3_wait_states),
      .area3_addr_ok(area3_addr_ok), .timer_irq(timer_irq),
      .refresh_strobe_out(refresh_strobe_out), .refresh_pin_oe(refresh_pin_oe),
      .upper_write_strobe_pin(), .lower_write_strobe_pin(), .read_strobe_pin(read_strobe_pin),
      .area3_select_pin(area3_select_pin), .dram_addr(dram_addr),
      .self_refresh_active(self_refresh_active)
   );
   dprc_mem_model i_dprc_mem_model
   (
      .hclk(hclk), .hresetn(hresetn), .slow(slow), .refresh_request(refresh_request),
      .read_strobe_pin(read_strobe_pin), .area3_select_pin(area3_select_pin),
      .bus_grant(bus_grant), .cbr_count(cbr_count)
   );
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
   begin
      comparisons++;
      if (seen !== exp)
      begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   end
   endtask
   task automatic bus(input logic w, input logic [31:0] a, input logic [7:0] d);
   begin
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {a[29:0], 2'b00};
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h000000, d};
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
   end
   endtask
   task automatic final_report;
   begin
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   end
   endtask
   initial
   begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   always @(posedge hclk)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_count++;
         final_report;
      end
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      hresetn = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
      hsize = 3'h2; hwdata = 32'h0; halt_req = 1'b0; hw_standby = 1'b0; sw_standby = 1'b0;
      wide_space_mode = 1'b0; area3_access = 1'b0; area3_addr = 21'h0; slow = 1'b0;
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      foreach (rows[i])
      begin
         bus(rows[i].w, rows[i].a, rows[i].d);
         if (!rows[i].w) chk(rd, {24'h0, rows[i].e});
      end
      $display("register table test done");
      bus(1, `DPRC_OFS_CNT, 8'h00);
      bus(1, `DPRC_OFS_TCSR, 8'h48);
      for (int i = 0; i < 400 && timer_irq !== 1'b1; i++) @(posedge hclk);
      chk(timer_irq, 1);
      bus(0, `DPRC_OFS_TCSR, 8'h00);
      chk(rd, 32'hcf);
      bus(1, `DPRC_OFS_TCSR, 8'h48);
      repeat (3) @(posedge hclk);
      chk(timer_irq, 0);
      halt_req <= 1'b1;
      repeat (4) @(posedge hclk);
      bus(0, `DPRC_OFS_CNT, 8'h00);
      v1 = rd;
      repeat (40) @(posedge hclk);
      bus(0, `DPRC_OFS_CNT, 8'h00);
      chk(rd, v1);
      halt_req <= 1'b0;
      $display("timer test done");
      bus(1, `DPRC_OFS_TCSR, 8'h08);
      bus(1, `DPRC_OFS_COR, 8'h03);
      bus(1, `DPRC_OFS_CNT, 8'h00);
      bus(1, `DPRC_OFS_CTRL, 8'h25);
      bus(0, `DPRC_OFS_CTRL, 8'h00);
      chk(rd, 32'h27);
      chk(refresh_pin_oe, 1);
      bus(1, `DPRC_OFS_CTRL, 8'h3a);
      bus(0, `DPRC_OFS_CTRL, 8'h00);
      chk(rd, 32'h27);
      bus(1, `DPRC_OFS_COR, 8'h99);
      bus(0, `DPRC_OFS_COR, 8'h00);
      chk(rd, 32'h03);
      chk(area3_three_state, 1);
      bus(1, `DPRC_OFS_MEMCFG, 8'h02);
      for (int i = 0; i < 300 && cbr_count == 0; i++) @(posedge hclk);
      chk(cbr_count != 0, 1);
      slow <= 1'b1;
      v1 = cbr_count;
      for (int i = 0; i < 300 && cbr_count <= v1; i++) @(posedge hclk);
      chk(cbr_count > v1, 1);
      area3_access <= 1'b1;
      area3_addr <= 21'h01ffff;
      repeat (4) @(posedge hclk);
      chk(area3_addr_ok, 1);
      chk(dram_addr, 10'h0ff);
      chk(area3_wait_states, 2'h2);
      area3_addr <= 21'h020000;
      repeat (4) @(posedge hclk);
      chk(area3_addr_ok, 0);
      chk(dram_addr, 10'h100);
      wide_space_mode <= 1'b1;
      repeat (4) @(posedge hclk);
      chk(area3_addr_ok, 1);
      $display("memory mode test done");
      bus(1, `DPRC_OFS_CTRL, 8'ha5);
      sw_standby <= 1'b1;
      for (int i = 0; i < 20 && self_refresh_active !== 1'b1; i++) @(posedge hclk);
      chk(self_refresh_active, 1);
      sw_standby <= 1'b0;
      repeat (8) @(posedge hclk);
      chk(self_refresh_active, 0);
      bus(1, `DPRC_OFS_CTRL, 8'h00);
      repeat (4) @(posedge hclk);
      hw_standby <= 1'b1;
      repeat (8) @(posedge hclk);
      hw_standby <= 1'b0;
      repeat (4) @(posedge hclk);
      bus(0, `DPRC_OFS_CTRL, 8'h00);
      chk(rd, 32'h02);
      bus(0, `DPRC_OFS_COR, 8'h00);
      chk(rd, 32'hff);
      bus(0, `DPRC_OFS_TCSR, 8'h00);
      chk(rd, 32'h07);
      $display("standby test done");
      final_report;
   end
endmodule // tb_dprc_top
`default_nettype wire
